//--- design/fmj_pkg.sv
// package: constants and carrier types of the instruction execution unit
package fmj_pkg;

    // ------
    // register map (byte addresses)
    // ------
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_INSTR = 8'h04;
    localparam logic [7:0] ADR_STATUS = 8'h08;
    localparam logic [7:0] ADR_PC = 8'h0C;
    localparam logic [7:0] ADR_SP = 8'h10;
    localparam logic [7:0] ADR_FLAGS = 8'h14;
    localparam logic [7:0] ADR_RIDX = 8'h18;
    localparam logic [7:0] ADR_RDAT = 8'h1C;

    // ------
    // fields and reset values
    // ------
    localparam int CTRL_PC22 = 0;
    localparam int CTRL_ENH = 1;
    localparam int FLG_C = 0;
    localparam int FLG_Z = 1;
    localparam int FLG_N = 2;
    localparam int FLG_V = 3;
    localparam int FLG_S = 4;
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [21:0] PC_RST = 22'h00_0000;
    localparam logic [15:0] SP_RST = 16'h00FF;
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [21:0] PC_MASK16 = 22'h00_FFFF;
    localparam logic [21:0] PC_MASK22 = 22'h3F_FFFF;
    localparam logic [4:0] R_LO = 5'h00;
    localparam logic [4:0] R_HI = 5'h01;
    localparam logic [4:0] R_ZL = 5'h1E;
    localparam logic [4:0] R_ZH = 5'h1F;
    localparam logic [4:0] MUL_BASE = 5'h10;
    localparam logic [1:0] PUSH16 = 2'h2;
    localparam logic [1:0] PUSH22 = 2'h3;

    // ------
    // opcode patterns
    // ------
    localparam logic [15:0] MSK_FMUL = 16'hFF88;
    localparam logic [15:0] PAT_FMUL = 16'h0388;
    localparam logic [15:0] OPC_ICALL = 16'h9509;
    localparam logic [15:0] OPC_IJMP = 16'h9409;
    localparam logic [15:0] MSK_IN = 16'hF800;
    localparam logic [15:0] PAT_IN = 16'hB000;
    localparam logic [15:0] MSK_ONE = 16'hFE0F;
    localparam logic [15:0] PAT_INC = 16'h9403;
    localparam logic [15:0] PAT_MCLR = 16'h9206;
    localparam logic [15:0] PAT_MSET = 16'h9205;
    localparam logic [15:0] PAT_MTGL = 16'h9207;
    localparam logic [15:0] MSK_LBR = 16'hFE0E;
    localparam logic [15:0] PAT_LBR = 16'h940C;

    // ------
    // cycle counts
    // ------
    localparam logic [2:0] CYC_MUL = 3'h2;
    localparam logic [2:0] CYC_CALL16 = 3'h3;
    localparam logic [2:0] CYC_CALL22 = 3'h4;
    localparam logic [2:0] CYC_ECALL16 = 3'h2;
    localparam logic [2:0] CYC_ECALL22 = 3'h3;
    localparam logic [2:0] CYC_IJMP = 3'h2;
    localparam logic [2:0] CYC_LBR = 3'h3;
    localparam logic [2:0] CYC_ONE = 3'h1;

    // ------
    // types
    // ------
    typedef enum logic [3:0] {
        OP_NONE, OP_FMUL, OP_ICALL, OP_IJMP, OP_IN, OP_INC, OP_LBR, OP_MCLR, OP_MSET, OP_MTGL
    } fmj_op_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_EXEC = 2'h1
    } fmj_state_t;

    typedef struct packed {
        logic [15:0] adr;
        logic [7:0] dat;
        logic we;
        logic re;
        logic lock;
    } fmj_dmem_req_t;

    typedef struct packed {
        logic [5:0] adr;
        logic re;
    } fmj_io_req_t;

    typedef struct packed {
        logic [15:0] prod;
        logic prod_c;
        logic prod_z;
        logic [7:0] inc_res;
        logic inc_v;
        logic inc_n;
        logic inc_z;
        logic inc_s;
        logic [7:0] rmw;
    } fmj_alu_t;

    localparam fmj_dmem_req_t DMEM_IDLE = '{16'h0000, 8'h00, 1'b0, 1'b0, 1'b0};
    localparam fmj_io_req_t IO_IDLE = '{6'h00, 1'b0};

endpackage

//--- design/fmj_alu.sv
// arithmetic of the execution unit: fractional product, increment, masked update
`timescale 1ns/100ps
`default_nettype none
module fmj_alu (
    // operands
    input wire logic [7:0] rd_i,
    input wire logic [7:0] src_i,
    input wire logic [7:0] mem_i,
    input wire fmj_pkg::fmj_op_t op_i,
    // results
    output var fmj_pkg::fmj_alu_t res_o
);
    logic [15:0] raw;
    logic [15:0] shl;
    logic [7:0] sum;

    always_comb begin
        // destination sign extended, source zero extended
        raw = {{8{rd_i[7]}}, rd_i} * {8'h00, src_i};
        shl = {raw[14:0], 1'b0};
        sum = rd_i + 8'h01;
        res_o.prod = shl;
        res_o.prod_c = raw[15];
        res_o.prod_z = shl == 16'h0000;
        res_o.inc_res = sum;
        res_o.inc_v = rd_i == 8'h7F;
        res_o.inc_n = sum[7];
        res_o.inc_z = sum == 8'h00;
        res_o.inc_s = sum[7] ^ (rd_i == 8'h7F);
        case (op_i)
            fmj_pkg::OP_MCLR: res_o.rmw = rd_i & (8'hFF - mem_i);
            fmj_pkg::OP_MSET: res_o.rmw = rd_i | mem_i;
            fmj_pkg::OP_MTGL: res_o.rmw = rd_i ^ mem_i;
            default: res_o.rmw = mem_i;
        endcase
    end
endmodule
`default_nettype wire

//--- design/fmj_exec.sv
// execution unit with wishbone registers, data space and I/O ports
//
// Local design decisions: the Wishbone slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - product is 16 bits, shifted left once
// - destination operand signed, source unsigned fractions
// - high byte to register 1, low to 0
// - operands registers 16..23 only; PC plus one
// - shift costs no cycle beyond integer multiply
// - carry from unshifted bit 15, zero flag
// - pointer call/jump load index, clear upper
// - call pushes two or three bytes
// - write at stack pointer, then decrement
// - call 3/4 cycles, enhanced 2/3
// - pointer jump reaches 64K, stack untouched
// - I/O load copies byte, flags kept
// - increment writes back, carry untouched
// - overflow only when operand was 7F
// - N, Z, S from result; one cycle
// - long branch loads constant, two-word opcode
// - clear/set/toggle memory byte at index
module fmj_exec (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // data space
    output var fmj_pkg::fmj_dmem_req_t dmem_o,
    input wire logic [7:0] dmem_dat_i,
    // I/O space
    output var fmj_pkg::fmj_io_req_t io_o,
    input wire logic [7:0] io_dat_i
);
    logic [1:0] ctrl_r;
    logic [31:0] instr_r;
    logic bad_r;
    logic [21:0] pc_r;
    logic [15:0] sp_r;
    logic [7:0] flags_r;
    logic [4:0] ridx_r;
    logic [7:0] rf_r [32];
    fmj_pkg::fmj_state_t state_r;
    fmj_pkg::fmj_op_t op_r;
    logic [2:0] cnt_r;
    logic [1:0] push_r;
    logic [23:0] ret_r;
    logic [15:0] sp_start_r;
    logic bus_req;
    logic bus_wr;
    logic start;
    logic busy;
    logic last;
    logic [31:0] cur_word;
    logic [31:0] wr_word;
    fmj_pkg::fmj_op_t new_op;
    logic [4:0] fld_d;
    logic [15:0] zptr;
    logic [21:0] pc_mask;
    logic [7:0] alu_a;
    logic [7:0] alu_b;
    fmj_pkg::fmj_alu_t alu;
    logic [15:0] fmul_raw;

    // ------
    // functions
    // ------
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                m[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return m;
    endfunction

    function automatic fmj_pkg::fmj_op_t decode(input logic [15:0] w);
        fmj_pkg::fmj_op_t op;
        op = fmj_pkg::OP_NONE;
        // encoding holds only 3-bit fields, so operands stay in 16..23
        if ((w & fmj_pkg::MSK_FMUL) == fmj_pkg::PAT_FMUL) begin
            op = fmj_pkg::OP_FMUL;
        end else if (w == fmj_pkg::OPC_ICALL) begin
            op = fmj_pkg::OP_ICALL;
        end else if (w == fmj_pkg::OPC_IJMP) begin
            op = fmj_pkg::OP_IJMP;
        end else if ((w & fmj_pkg::MSK_IN) == fmj_pkg::PAT_IN) begin
            op = fmj_pkg::OP_IN;
        end else if ((w & fmj_pkg::MSK_ONE) == fmj_pkg::PAT_INC) begin
            op = fmj_pkg::OP_INC;
        end else if ((w & fmj_pkg::MSK_LBR) == fmj_pkg::PAT_LBR) begin
            op = fmj_pkg::OP_LBR;
        end else if ((w & fmj_pkg::MSK_ONE) == fmj_pkg::PAT_MCLR) begin
            op = fmj_pkg::OP_MCLR;
        end else if ((w & fmj_pkg::MSK_ONE) == fmj_pkg::PAT_MSET) begin
            op = fmj_pkg::OP_MSET;
        end else if ((w & fmj_pkg::MSK_ONE) == fmj_pkg::PAT_MTGL) begin
            op = fmj_pkg::OP_MTGL;
        end
        return op;
    endfunction

    function automatic logic is_rmw(input fmj_pkg::fmj_op_t op);
        return op == fmj_pkg::OP_MCLR || op == fmj_pkg::OP_MSET || op == fmj_pkg::OP_MTGL;
    endfunction

    function automatic logic [2:0] cycles(input fmj_pkg::fmj_op_t op, input logic [1:0] c);
        logic [2:0] n;
        n = fmj_pkg::CYC_ONE;
        case (op)
            fmj_pkg::OP_FMUL: n = fmj_pkg::CYC_MUL;
            fmj_pkg::OP_ICALL: begin
                if (c[fmj_pkg::CTRL_ENH]) begin
                    n = c[fmj_pkg::CTRL_PC22] ? fmj_pkg::CYC_ECALL22 : fmj_pkg::CYC_ECALL16;
                end else begin
                    n = c[fmj_pkg::CTRL_PC22] ? fmj_pkg::CYC_CALL22 : fmj_pkg::CYC_CALL16;
                end
            end
            fmj_pkg::OP_IJMP: n = fmj_pkg::CYC_IJMP;
            fmj_pkg::OP_LBR: n = fmj_pkg::CYC_LBR;
            default: n = fmj_pkg::CYC_ONE;
        endcase
        return n;
    endfunction

    // ------
    // decode and bus glue
    // ------
    always_comb begin
        bus_req = wb_cyc_i && wb_stb_i;
        busy = state_r == fmj_pkg::ST_EXEC;
        // writes land on the acked edge; refused while executing
        bus_wr = bus_req && wb_we_i && wb_ack_o && !busy;
        start = bus_wr && wb_adr_i == fmj_pkg::ADR_INSTR;
        last = busy && cnt_r == 3'h0;
        fld_d = instr_r[8:4];
        zptr = {rf_r[fmj_pkg::R_ZH], rf_r[fmj_pkg::R_ZL]};
        pc_mask = ctrl_r[fmj_pkg::CTRL_PC22] ? fmj_pkg::PC_MASK22 : fmj_pkg::PC_MASK16;
    end

    always_comb begin
        case (wb_adr_i)
            fmj_pkg::ADR_CTRL: cur_word = {30'h0, ctrl_r};
            fmj_pkg::ADR_INSTR: cur_word = instr_r;
            fmj_pkg::ADR_STATUS: cur_word = {30'h0, bad_r, busy};
            fmj_pkg::ADR_PC: cur_word = {10'h000, pc_r};
            fmj_pkg::ADR_SP: cur_word = {16'h0000, sp_r};
            fmj_pkg::ADR_FLAGS: cur_word = {24'h00_0000, flags_r};
            fmj_pkg::ADR_RIDX: cur_word = {27'h0, ridx_r};
            fmj_pkg::ADR_RDAT: cur_word = {24'h00_0000, rf_r[ridx_r]};
            default: cur_word = 32'h0000_0000;
        endcase
        wr_word = merge(cur_word, wb_dat_i, wb_sel_i);
        new_op = decode(wr_word[15:0]);
    end

    always_comb begin
        if (op_r == fmj_pkg::OP_FMUL) begin
            alu_a = rf_r[fmj_pkg::MUL_BASE | {2'h0, instr_r[6:4]}];
            alu_b = rf_r[fmj_pkg::MUL_BASE | {2'h0, instr_r[2:0]}];
        end else begin
            alu_a = rf_r[fld_d];
            alu_b = 8'h00;
        end
    end

    fmj_alu u_alu (
        .rd_i(alu_a),
        .src_i(alu_b),
        .mem_i(dmem_dat_i),
        .op_i(op_r),
        .res_o(alu)
    );

    // ------
    // wishbone answer
    // ------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req && !wb_ack_o;
            if (bus_req && !wb_ack_o) begin
                wb_dat_o <= cur_word;
            end
        end
    end

    // ------
    // configuration
    // ------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= fmj_pkg::CTRL_RST;
            ridx_r <= 5'h00;
            instr_r <= 32'h0000_0000;
            bad_r <= 1'b0;
        end else if (bus_wr) begin
            case (wb_adr_i)
                fmj_pkg::ADR_CTRL: ctrl_r <= wr_word[1:0];
                fmj_pkg::ADR_RIDX: ridx_r <= wr_word[4:0];
                fmj_pkg::ADR_INSTR: begin
                    instr_r <= wr_word;
                    bad_r <= new_op == fmj_pkg::OP_NONE;
                end
                default: begin
                end
            endcase
        end
    end

    // ------
    // sequencer
    // ------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= fmj_pkg::ST_IDLE;
            op_r <= fmj_pkg::OP_NONE;
            cnt_r <= 3'h0;
        end else begin
            unique case (state_r)
                fmj_pkg::ST_IDLE: begin
                    if (start && new_op != fmj_pkg::OP_NONE) begin
                        state_r <= fmj_pkg::ST_EXEC;
                        op_r <= new_op;
                        cnt_r <= cycles(new_op, ctrl_r) - 3'h1;
                    end
                end
                fmj_pkg::ST_EXEC: begin
                    if (cnt_r == 3'h0) begin
                        state_r <= fmj_pkg::ST_IDLE;
                    end else begin
                        cnt_r <= cnt_r - 3'h1;
                    end
                end
                default: state_r <= fmj_pkg::ST_IDLE;
            endcase
        end
    end

    // ------
    // stack pointer and return address
    // ------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sp_r <= fmj_pkg::SP_RST;
            sp_start_r <= fmj_pkg::SP_RST;
            ret_r <= 24'h00_0000;
            push_r <= 2'h0;
        end else if (start) begin
            ret_r <= {2'h0, (pc_r + 22'h00_0001) & pc_mask};
            sp_start_r <= sp_r;
            if (new_op == fmj_pkg::OP_ICALL) begin
                push_r <= ctrl_r[fmj_pkg::CTRL_PC22] ? fmj_pkg::PUSH22 : fmj_pkg::PUSH16;
            end else begin
                push_r <= 2'h0;
            end
        end else if (bus_wr && wb_adr_i == fmj_pkg::ADR_SP) begin
            sp_r <= wr_word[15:0];
        end else if (busy && push_r != 2'h0) begin
            // byte goes out at the old pointer, low byte first
            sp_r <= sp_r - 16'h0001;
            ret_r <= {8'h00, ret_r[23:8]};
            push_r <= push_r - 2'h1;
        end
    end

    // ------
    // data space port
    // ------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dmem_o <= fmj_pkg::DMEM_IDLE;
        end else begin
            dmem_o.we <= 1'b0;
            dmem_o.re <= 1'b0;
            if (start && is_rmw(new_op)) begin
                // lock spans read and write so nobody slips in between
                dmem_o.adr <= zptr;
                dmem_o.re <= 1'b1;
                dmem_o.lock <= 1'b1;
            end else if (busy && push_r != 2'h0) begin
                dmem_o.adr <= sp_r;
                dmem_o.dat <= ret_r[7:0];
                dmem_o.we <= 1'b1;
            end else if (last && is_rmw(op_r)) begin
                dmem_o.dat <= alu.rmw;
                dmem_o.we <= 1'b1;
            end else if (dmem_o.we) begin
                dmem_o.lock <= 1'b0;
            end
        end
    end

    // ------
    // I/O port
    // ------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            io_o <= fmj_pkg::IO_IDLE;
        end else begin
            io_o.re <= start && new_op == fmj_pkg::OP_IN;
            if (start && new_op == fmj_pkg::OP_IN) begin
                io_o.adr <= {wr_word[10:9], wr_word[3:0]};
            end
        end
    end

    // ------
    // program counter
    // ------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pc_r <= fmj_pkg::PC_RST;
        end else if (bus_wr && wb_adr_i == fmj_pkg::ADR_PC) begin
            pc_r <= wr_word[21:0] & pc_mask;
        end else if (last) begin
            case (op_r)
                fmj_pkg::OP_ICALL, fmj_pkg::OP_IJMP: pc_r <= {6'h00, zptr};
                fmj_pkg::OP_LBR: begin
                    pc_r <= {instr_r[8:4], instr_r[0], instr_r[31:16]} & pc_mask;
                end
                default: pc_r <= (pc_r + 22'h00_0001) & pc_mask;
            endcase
        end
    end

    // ------
    // flag word
    // ------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_r <= fmj_pkg::FLAGS_RST;
        end else if (bus_wr && wb_adr_i == fmj_pkg::ADR_FLAGS) begin
            flags_r <= wr_word[7:0];
        end else if (last && op_r == fmj_pkg::OP_FMUL) begin
            flags_r[fmj_pkg::FLG_C] <= alu.prod_c;
            flags_r[fmj_pkg::FLG_Z] <= alu.prod_z;
        end else if (last && op_r == fmj_pkg::OP_INC) begin
            flags_r[fmj_pkg::FLG_V] <= alu.inc_v;
            flags_r[fmj_pkg::FLG_N] <= alu.inc_n;
            flags_r[fmj_pkg::FLG_Z] <= alu.inc_z;
            flags_r[fmj_pkg::FLG_S] <= alu.inc_s;
        end
    end

    // ------
    // register file
    // ------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < 32; i++) begin
                rf_r[i] <= 8'h00;
            end
        end else if (bus_wr && wb_adr_i == fmj_pkg::ADR_RDAT) begin
            rf_r[ridx_r] <= wr_word[7:0];
        end else if (last) begin
            case (op_r)
                fmj_pkg::OP_FMUL: begin
                    rf_r[fmj_pkg::R_HI] <= alu.prod[15:8];
                    rf_r[fmj_pkg::R_LO] <= alu.prod[7:0];
                end
                fmj_pkg::OP_INC: rf_r[fld_d] <= alu.inc_res;
                fmj_pkg::OP_IN: rf_r[fld_d] <= io_dat_i;
                fmj_pkg::OP_MCLR, fmj_pkg::OP_MSET, fmj_pkg::OP_MTGL: begin
                    rf_r[fld_d] <= dmem_dat_i;
                end
                default: begin
                end
            endcase
        end
    end

    // ------
    // checks
    // ------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    always_comb begin
        fmul_raw = {{8{alu_a[7]}}, alu_a} * {8'h00, alu_b};
    end

    sequence busy2_s;
        busy [*2] ##1 !busy;
    endsequence

    sequence busy3_s;
        busy [*3] ##1 !busy;
    endsequence

    sequence rmw_s;
        (dmem_o.lock && dmem_o.re) ##1 (dmem_o.lock && dmem_o.we);
    endsequence

    fmul_time_a: assert property (
        start && new_op == fmj_pkg::OP_FMUL |=> busy2_s)
        else $error("fractional multiply not two cycles");
    fmul_result_a: assert property (
        last && op_r == fmj_pkg::OP_FMUL |=>
        {rf_r[1], rf_r[0]} == {$past(fmul_raw[14:0]), 1'b0})
        else $error("fractional product wrong");
    fmul_flags_a: assert property (
        last && op_r == fmj_pkg::OP_FMUL |=> flags_r[0] == $past(fmul_raw[15])
        && flags_r[1] == ($past(fmul_raw[14:0]) == 15'h0000)
        && flags_r[7:2] == $past(flags_r[7:2]))
        else $error("fractional multiply flags wrong");
    call_time_a: assert property (
        start && new_op == fmj_pkg::OP_ICALL && ctrl_r == 2'h0 |=> busy3_s)
        else $error("pointer call not three cycles");
    ecall_time_a: assert property (
        start && new_op == fmj_pkg::OP_ICALL && ctrl_r == 2'h3 |=> busy3_s)
        else $error("enhanced pointer call not three cycles");
    call_stack_a: assert property (
        last && op_r == fmj_pkg::OP_ICALL |=>
        sp_r == sp_start_r - (ctrl_r[0] ? 16'h0003 : 16'h0002))
        else $error("call stack depth wrong");
    push_order_a: assert property (
        dmem_o.we && !dmem_o.lock |-> sp_r == dmem_o.adr - 16'h0001)
        else $error("push not post-decrement");
    ptr_target_a: assert property (
        last && (op_r == fmj_pkg::OP_ICALL || op_r == fmj_pkg::OP_IJMP) |=>
        pc_r == {6'h00, $past(zptr)})
        else $error("pointer target wrong");
    jump_stack_a: assert property (
        busy && op_r == fmj_pkg::OP_IJMP |=> !dmem_o.we && $stable(sp_r))
        else $error("pointer jump touched stack");
    inc_flags_a: assert property (
        last && op_r == fmj_pkg::OP_INC |=> flags_r[3] == ($past(alu_a) == 8'h7F)
        && flags_r[0] == $past(flags_r[0]))
        else $error("increment flags wrong");
    io_load_a: assert property (
        last && op_r == fmj_pkg::OP_IN |=> $stable(flags_r)
        && rf_r[$past(fld_d)] == $past(io_dat_i))
        else $error("I/O load wrong");
    rmw_lock_a: assert property (
        start && is_rmw(new_op) |=> rmw_s)
        else $error("memory update not locked");
endmodule
`default_nettype wire

//--- test/fmj_dspace_model.sv
// data space and I/O space model facing the execution unit
`timescale 1ns/100ps
`default_nettype none
module fmj_dspace_model (
    // clock
    input wire logic clk_i,
    // data space
    input wire fmj_pkg::fmj_dmem_req_t dmem_i,
    output logic [7:0] dmem_dat_o,
    // I/O space
    input wire fmj_pkg::fmj_io_req_t io_i,
    output logic [7:0] io_dat_o
);
    // ----------
    // storage
    // ----------
    logic [7:0] mem [0:255];
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] <= i[7:0];
        end
    end
    always @(posedge clk_i) begin
        if (dmem_i.we) begin
            mem[dmem_i.adr[7:0]] <= dmem_i.dat;
        end
    end
    // idle lines show the inverse, so stale data never looks valid
    assign dmem_dat_o = dmem_i.re ? mem[dmem_i.adr[7:0]] : ~mem[dmem_i.adr[7:0]];
    assign io_dat_o = io_i.re ? {2'b11, io_i.adr} : {2'b00, ~io_i.adr};
endmodule
`default_nettype wire

//--- test/frac_mul_jump_incr_exec_tb_top.sv
// testbench of the execution unit driven over wishbone
`timescale 1ns/100ps
`default_nettype none
module frac_mul_jump_incr_exec_tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] q;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    fmj_pkg::fmj_dmem_req_t dmem;
    fmj_pkg::fmj_io_req_t io;
    logic [7:0] ddat;
    logic [7:0] idat;
    int err_total = 0;
    int checks = 0;
    int cyc_cnt = 0;
    logic [15:0] ops [3] = '{16'h9235, 16'h9237, 16'h9236};
    logic [7:0] rexp [3] = '{8'h40, 8'h4F, 8'h0F};
    logic [7:0] mexp [3] = '{8'h4F, 8'h0F, 8'h40};

    fmj_exec u_fmj_exec (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .dmem_o(dmem), .dmem_dat_i(ddat), .io_o(io), .io_dat_i(idat));
    fmj_dspace_model u_fmj_dspace_model (.clk_i(clk_i), .dmem_i(dmem), .dmem_dat_o(ddat),
        .io_i(io), .io_dat_o(idat));

    initial begin
        forever #25 clk_i = ~clk_i;
    end

    // ----------
    // bus tasks
    // ----------
    task automatic results();
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // far above the few hundred cycles the sequence needs
    always @(posedge clk_i) begin
        cyc_cnt++;
        if (cyc_cnt == 5000) begin
            err_total++;
            results();
        end
    end

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic chk(input logic [31:0] e, input logic [31:0] g, input string nm);
        checks++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
        wb(1'b0, a, 32'h0000_0000);
        chk(e, q, nm);
    endtask

    task automatic setr(input logic [4:0] i, input logic [7:0] v);
        wb(1'b1, fmj_pkg::ADR_RIDX, 32'(i));
        wb(1'b1, fmj_pkg::ADR_RDAT, 32'(v));
    endtask

    task automatic getr(input logic [4:0] i, input logic [7:0] e, input string nm);
        wb(1'b1, fmj_pkg::ADR_RIDX, 32'(i));
        rdc(fmj_pkg::ADR_RDAT, 32'(e), nm);
    endtask

    // polling keeps every new opcode clear of the busy window
    task automatic run(input logic [31:0] op);
        wb(1'b1, fmj_pkg::ADR_INSTR, op);
        do wb(1'b0, fmj_pkg::ADR_STATUS, 32'h0000_0000); while (q[0] !== 1'b0);
    endtask

    // ----------
    // sequence
    // ----------
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc(fmj_pkg::ADR_PC, 32'h0000_0000, "pc reset");
        rdc(fmj_pkg::ADR_SP, 32'h0000_00FF, "sp reset");
        rdc(8'h20, 32'h0000_0000, "unmapped");
        setr(5'h10, 8'h80);
        setr(5'h11, 8'hFF);
        run(32'h0000_0389);
        getr(5'h01, 8'h01, "r1");
        getr(5'h00, 8'h00, "r0");
        rdc(fmj_pkg::ADR_FLAGS, 32'h0000_0001, "flags mul");
        rdc(fmj_pkg::ADR_PC, 32'h0000_0001, "pc mul");
        setr(5'h05, 8'h7F);
        run(32'h0000_9453);
        getr(5'h05, 8'h80, "r5");
        rdc(fmj_pkg::ADR_FLAGS, 32'h0000_000D, "flags inc");
        run(32'h0000_B47A);
        getr(5'h07, 8'hEA, "r7");
        rdc(fmj_pkg::ADR_FLAGS, 32'h0000_000D, "flags in");
        rdc(fmj_pkg::ADR_PC, 32'h0000_0003, "pc in");
        setr(5'h1E, 8'h40);
        setr(5'h1F, 8'h00);
        setr(5'h03, 8'h0F);
        for (int i = 0; i < 3; i++) begin
            run({16'h0000, ops[i]});
            getr(5'h03, rexp[i], "rmw reg");
            chk(32'(mexp[i]), 32'(u_fmj_dspace_model.mem[8'h40]), "rmw mem");
        end
        run(32'h0000_9509);
        rdc(fmj_pkg::ADR_PC, 32'h0000_0040, "pc call");
        rdc(fmj_pkg::ADR_SP, 32'h0000_00FD, "sp call");
        chk(32'h0000_0007, 32'(u_fmj_dspace_model.mem[8'hFF]), "ret lo");
        chk(32'h0000_0000, 32'(u_fmj_dspace_model.mem[8'hFE]), "ret hi");
        wb(1'b1, fmj_pkg::ADR_CTRL, 32'h0000_0001);
        wb(1'b1, fmj_pkg::ADR_PC, 32'h003F_0000);
        run(32'h0000_9409);
        rdc(fmj_pkg::ADR_PC, 32'h0000_0040, "pc ijmp");
        rdc(fmj_pkg::ADR_SP, 32'h0000_00FD, "sp ijmp");
        run(32'h0000_9509);
        rdc(fmj_pkg::ADR_SP, 32'h0000_00FA, "sp call22");
        chk(32'h0000_0041, 32'(u_fmj_dspace_model.mem[8'hFD]), "ret22 lo");
        chk(32'h0000_0000, 32'(u_fmj_dspace_model.mem[8'hFB]), "ret22 hi");
        run(32'hABCD_940D);
        rdc(fmj_pkg::ADR_PC, 32'h0001_ABCD, "pc lbr");
        rdc(fmj_pkg::ADR_SP, 32'h0000_00FA, "sp lbr");
        wb(1'b1, fmj_pkg::ADR_CTRL, 32'h0000_0003);
        run(32'h0000_9509);
        rdc(fmj_pkg::ADR_SP, 32'h0000_00F7, "sp ecall22");
        chk(32'h0000_00CE, 32'(u_fmj_dspace_model.mem[8'hFA]), "ecall lo");
        chk(32'h0000_0001, 32'(u_fmj_dspace_model.mem[8'hF8]), "ecall hi");
        rdc(fmj_pkg::ADR_PC, 32'h0000_0040, "pc ecall");
        run(32'h0000_0000);
        rdc(fmj_pkg::ADR_STATUS, 32'h0000_0002, "status bad");
        rdc(fmj_pkg::ADR_PC, 32'h0000_0040, "pc bad");
        results();
    end
endmodule
`default_nettype wire
